// file: logic/monitor_pkg.sv
/*
 * Constants, field layouts and types shared by the input power monitor.
 * Assumes a single sample clock domain for the monitor and its host port.
 */
package monitor_pkg;

   // ==========================================================
   // Widths of the sample, period and result fields.
   // ==========================================================
   localparam int PERIOD_W  = 24;
   localparam int MAG_W     = 15;
   localparam int THR_W     = 10;
   localparam int MEAN_W    = 6;
   localparam int EXP_W     = 4;
   localparam int MANT_W    = 20;
   localparam int SEL_W     = 2;

   // ==========================================================
   // Field positions.
   // ==========================================================
   localparam int MEAN_SHIFT  = 9;
   localparam int SEL_THR_BIT = 1;
   localparam int SEL_LOW_BIT = 0;
   localparam int THR_LSB     = MAG_W - THR_W;

   // ==========================================================
   // Reset values and timing counts.
   // ==========================================================
   localparam logic [PERIOD_W-1:0] PERIOD_RST = 24'h000000;
   localparam logic [PERIOD_W-1:0] STORE_RST  = 24'h000000;
   localparam logic [PERIOD_W-1:0] HOLD_RST   = 24'h000000;
   localparam logic [PERIOD_W-1:0] TIMER_LAST = 24'h000001;
   localparam logic [PERIOD_W-1:0] COUNT_STEP = 24'h000001;
   localparam logic [4:0]          ZERO_ALL   = 5'h18;
   localparam logic [4:0]          SHIFT_MAX  = 5'h0F;

   // ==========================================================
   // Types.
   // ==========================================================
   typedef logic [PERIOD_W-1:0] word_t;

   typedef enum logic [1:0] {
      MODE_PEAK   = 2'h0,
      MODE_MEAN   = 2'h1,
      MODE_THRESH = 2'h3
   } mode_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } run_e;

endpackage

// file: logic/mean_format_if.sv
/*
 * Carrier between the monitor core and its mean result formatter.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/10ps

interface mean_format_if;
   import monitor_pkg::*;

   word_t                  accum;
   logic [EXP_W-1:0]       expo;
   logic [MANT_W-1:0]      mant;

   modport source (output accum, input expo, input mant);
   modport shaper (input accum, output expo, output mant);
endinterface

// file: logic/mean_float_shaper.sv
/*
 * Turns the 24-bit mean accumulator into a 4-bit exponent and a 20-bit
 * mantissa. Assumes the caller registers the result.
 */
`timescale 1ns/10ps

module mean_float_shaper (
   mean_format_if.shaper fmt
);
   import monitor_pkg::*;

   logic [4:0]  zeros;
   logic [3:0]  shift;
   word_t       normal;

   // ==========================================================
   // Leading zero count.
   // ==========================================================
   // The highest set bit is seen last, so it decides the count.
   always_comb begin
      zeros = ZERO_ALL;
      for (int i = 0; i < PERIOD_W; i++) begin
         if (fmt.accum[i]) begin
            zeros = 5'(PERIOD_W - 1 - i);
         end
      end
   end

   // ==========================================================
   // Normalisation.
   // ==========================================================
   // The exponent saturates at its field width; small sums keep leading
   // zeros in the mantissa instead.
   always_comb begin
      if (zeros > SHIFT_MAX) begin
         shift = SHIFT_MAX[3:0];
      end else begin
         shift = zeros[3:0];
      end
      normal   = fmt.accum << shift;
      fmt.expo = shift;
      fmt.mant = normal[PERIOD_W-1:PERIOD_W-MANT_W];
   end

endmodule

// file: logic/input_power_monitor.sv
/*
 * Statistics block on the digitised input sample stream: peak magnitude,
 * mean magnitude or threshold crossing count over a programmed period,
 * moved into a holding register that the host reads.
 * Assumes samples and host strobes are produced on mclk, so no input
 * needs a synchroniser; a read strobe held high counts as one read.
 */
`timescale 1ns/10ps

// Operation
// - Two-bit select chooses peak, mean, or threshold counting.
// - Any select with upper bit set means threshold counting.
// - Exactly one function runs, repeating period after period.
// - 24-bit period loads a countdown on mode entry, counting at once.
// - Peak mode keeps the larger of input and storage.
// - At count one, transfer storage, reload timer, restart measurement.
// - Mean mode adds magnitude shifted right nine into 24-bit sum.
// - Mean restart loads the first sample, then accumulates.
// - Mean result is 4-bit exponent over 20-bit mantissa.
// - Threshold mode counts samples above the 10-bit upper threshold.
// - Threshold count clears to zero after each transfer except a read with clear-on-read off.
// - Threshold compare shares the gain control upper threshold.
// - Count one sets interrupt status; enabled status drives the pin.
// - Timer-disable keeps counting but stops transfers at count one.
// - Timer-disable lets a holding read transfer and reload timer.
// - Timer-disable still raises the interrupt at count one.
// - Clear-on-read matters only while timer-disable is set.
// - Both bits set: a read restarts storage and the loop.
// - Clear-on-read off: storage continues from its previous value.
module input_power_monitor (
   input  wire logic                             mclk,
   input  wire logic                             rst,
   input  wire logic [monitor_pkg::MAG_W-1:0]    sampleMag,
   input  wire logic                             periodWrite,
   input  wire monitor_pkg::word_t               periodData,
   input  wire logic                             monitorEnable,
   input  wire logic [monitor_pkg::SEL_W-1:0]    functionSelect,
   input  wire logic [monitor_pkg::THR_W-1:0]    upperThreshold,
   input  wire logic                             timerDisable,
   input  wire logic                             clearOnRead,
   input  wire logic                             irqEnable,
   input  wire logic                             irqClear,
   input  wire logic                             holdRead,
   output monitor_pkg::word_t                    holdingValue,
   output monitor_pkg::word_t                    monitorPeriodLength,
   output logic                                  monitorActive,
   output logic                                  irqStatus,
   output logic                                  interrupt_request_pin
);
   import monitor_pkg::*;

   // ==========================================================
   // Declarations.
   // ==========================================================
   run_e                runState_ff;
   run_e                nxt_runState;
   mode_e               mode_ff;
   mode_e               selMode;
   word_t               periodLength_ff;
   word_t               timer_ff;
   word_t               nxt_timer;
   word_t               magnitudeStorage_ff;
   word_t               nxt_magnitudeStorage;
   word_t               holding_ff;
   word_t               nxt_holding;
   word_t               restartValue;
   word_t               runValue;
   word_t               magWide;
   word_t               meanWide;
   logic [MEAN_W-1:0]   meanStep;
   logic [THR_W-1:0]    magTop;
   logic                overThreshold;
   logic                irqStatus_ff;
   logic                irqPin_ff;
   logic                holdReadPrev_ff;
   logic                readStrobe;
   logic                startMode;
   logic                periodEnd;
   logic                autoTransfer;
   logic                readTransfer;
   logic                anyTransfer;
   logic                reloadTimer;
   logic                restartStore;

   mean_format_if       meanFmt ();

   // ==========================================================
   // Mean result formatter.
   // ==========================================================
   mean_float_shaper shaper (
      .fmt (meanFmt.shaper)
   );

   assign meanFmt.accum = magnitudeStorage_ff;

   // ==========================================================
   // Function select decode.
   // ==========================================================
   // The lower select bit is a don't care once the upper bit is set.
   always_comb begin
      if (functionSelect[SEL_THR_BIT]) begin
         selMode = MODE_THRESH;
      end else if (functionSelect[SEL_LOW_BIT]) begin
         selMode = MODE_MEAN;
      end else begin
         selMode = MODE_PEAK;
      end
   end

   // ==========================================================
   // Sample derived terms.
   // ==========================================================
   // The threshold compares against the ten most significant magnitude
   // bits, the same view that the gain control logic takes.
   always_comb begin
      magWide       = word_t'(sampleMag);
      meanStep      = MEAN_W'(sampleMag >> MEAN_SHIFT);
      meanWide      = word_t'(meanStep);
      magTop        = sampleMag[MAG_W-1:THR_LSB];
      overThreshold = magTop > upperThreshold;
   end

   // ==========================================================
   // Period length register.
   // ==========================================================
   // A write while a mode runs takes effect at the next reload only.
   always_ff @(posedge mclk) begin
      if (rst) begin
         periodLength_ff <= PERIOD_RST;
      end else if (periodWrite) begin
         periodLength_ff <= periodData;
      end
   end

   // ==========================================================
   // Host read strobe.
   // ==========================================================
   // Only the first cycle of a read counts, so a host port that holds
   // its strobe for several cycles cannot transfer or clear the storage
   // more than once per access.
   always_ff @(posedge mclk) begin
      if (rst) begin
         holdReadPrev_ff <= 1'b0;
      end else begin
         holdReadPrev_ff <= holdRead;
      end
   end

   assign readStrobe = holdRead && !holdReadPrev_ff;

   // ==========================================================
   // Run control.
   // ==========================================================
   // A new mode is entered when the monitor is enabled from idle or when
   // the decoded function changes while running; only one function is ever live.
   always_comb begin
      startMode = monitorEnable &&
                  (runState_ff == ST_IDLE || selMode != mode_ff);
      if (monitorEnable) begin
         nxt_runState = ST_RUN;
      end else begin
         nxt_runState = ST_IDLE;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         runState_ff <= ST_IDLE;
      end else begin
         runState_ff <= nxt_runState;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_ff <= MODE_PEAK;
      end else if (startMode) begin
         mode_ff <= selMode;
      end
   end

   // ==========================================================
   // Period end and transfer events.
   // ==========================================================
   // Mode entry outranks both period end and a host read in the same
   // cycle, since the measurement is being thrown away anyway.
   always_comb begin
      periodEnd    = runState_ff == ST_RUN && monitorEnable &&
                     !startMode && timer_ff == TIMER_LAST;
      autoTransfer = periodEnd && !timerDisable;
      readTransfer = runState_ff == ST_RUN && monitorEnable &&
                     !startMode && readStrobe && timerDisable;
      anyTransfer  = autoTransfer || readTransfer;
      reloadTimer  = startMode || periodEnd || readTransfer;
      restartStore = startMode || autoTransfer ||
                     (readTransfer && clearOnRead);
   end

   // ==========================================================
   // Monitor period timer.
   // ==========================================================
   // With transfers disabled the timer still wraps at one so that the
   // interrupt keeps its rhythm.
   always_comb begin
      if (reloadTimer) begin
         nxt_timer = periodLength_ff;
      end else if (runState_ff == ST_RUN) begin
         nxt_timer = timer_ff - COUNT_STEP;
      end else begin
         nxt_timer = timer_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         timer_ff <= PERIOD_RST;
      end else begin
         timer_ff <= nxt_timer;
      end
   end

   // ==========================================================
   // Magnitude storage.
   // ==========================================================
   // Restart value: the current sample for peak and mean, zero for the
   // crossing count.
   always_comb begin
      case (selMode)
         MODE_PEAK: begin
            restartValue = magWide;
         end
         MODE_MEAN: begin
            restartValue = meanWide;
         end
         default: begin
            restartValue = STORE_RST;
         end
      endcase
   end

   // Running update for the function that is live.
   always_comb begin
      case (mode_ff)
         MODE_PEAK: begin
            if (magWide > magnitudeStorage_ff) begin
               runValue = magWide;
            end else begin
               runValue = magnitudeStorage_ff;
            end
         end
         MODE_MEAN: begin
            runValue = magnitudeStorage_ff + meanWide;
         end
         default: begin
            if (overThreshold) begin
               runValue = magnitudeStorage_ff + COUNT_STEP;
            end else begin
               runValue = magnitudeStorage_ff;
            end
         end
      endcase
   end

   // Without a restart, storage carries on from its old value, including
   // right after a host read with clear-on-read off.
   always_comb begin
      if (restartStore) begin
         nxt_magnitudeStorage = restartValue;
      end else if (runState_ff == ST_RUN) begin
         nxt_magnitudeStorage = runValue;
      end else begin
         nxt_magnitudeStorage = magnitudeStorage_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         magnitudeStorage_ff <= STORE_RST;
      end else begin
         magnitudeStorage_ff <= nxt_magnitudeStorage;
      end
   end

   // ==========================================================
   // Holding register.
   // ==========================================================
   // The transfer takes storage as it stood before this cycle's sample.
   always_comb begin
      if (anyTransfer) begin
         if (mode_ff == MODE_MEAN) begin
            nxt_holding = {meanFmt.expo, meanFmt.mant};
         end else begin
            nxt_holding = magnitudeStorage_ff;
         end
      end else begin
         nxt_holding = holding_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         holding_ff <= HOLD_RST;
      end else begin
         holding_ff <= nxt_holding;
      end
   end

   // ==========================================================
   // Interrupt status and pin.
   // ==========================================================
   // A period end in the clear cycle keeps the status set.
   always_ff @(posedge mclk) begin
      if (rst) begin
         irqStatus_ff <= 1'b0;
      end else if (periodEnd) begin
         irqStatus_ff <= 1'b1;
      end else if (irqClear) begin
         irqStatus_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irqPin_ff <= 1'b0;
      end else begin
         irqPin_ff <= irqEnable &&
                      (irqStatus_ff || periodEnd);
      end
   end

   // ==========================================================
   // Outputs.
   // ==========================================================
   // The pin comes from its own flip-flop, so it never glitches.
   assign holdingValue          = holding_ff;
   assign monitorPeriodLength   = periodLength_ff;
   assign monitorActive         = runState_ff == ST_RUN;
   assign irqStatus             = irqStatus_ff;
   assign interrupt_request_pin = irqPin_ff;

endmodule

// file: verification/sample_source.sv
/*
 * Sample stream source that stands in for the converter feeding the monitor.
 * Assumes the bench sets the level to present, on the same mclk.
 */
`timescale 1ns/10ps

module sample_source (
   input  wire logic                          mclk,
   input  wire logic                          rst,
   input  wire logic [monitor_pkg::MAG_W-1:0] level,
   output logic      [monitor_pkg::MAG_W-1:0] sampleMag
);
   import monitor_pkg::*;

   // ==========================================================
   // One new magnitude per input clock cycle.
   always_ff @(posedge mclk) begin
      if (rst) begin
         sampleMag <= 15'h0000;
      end else begin
         sampleMag <= level;
      end
   end
endmodule

// file: verification/input_power_monitor_properties.sv
/*
 * Timing checks on the ports of the input power monitor.
 * Assumes one clock domain and a synchronous active high reset.
 */
`timescale 1ns/10ps

module input_power_monitor_properties
   import monitor_pkg::*;
(
   input wire logic                          mclk,
   input wire logic                          rst,
   input wire logic [monitor_pkg::MAG_W-1:0] sampleMag,
   input wire logic                          periodWrite,
   input wire monitor_pkg::word_t            periodData,
   input wire logic                          monitorEnable,
   input wire logic [monitor_pkg::SEL_W-1:0] functionSelect,
   input wire logic [monitor_pkg::THR_W-1:0] upperThreshold,
   input wire logic                          timerDisable,
   input wire logic                          clearOnRead,
   input wire logic                          irqEnable,
   input wire logic                          irqClear,
   input wire logic                          holdRead,
   input wire monitor_pkg::word_t            holdingValue,
   input wire monitor_pkg::word_t            monitorPeriodLength,
   input wire logic                          monitorActive,
   input wire logic                          irqStatus,
   input wire logic                          interrupt_request_pin
);
   // ==========================================================
   // Properties.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence entry_s;
      $rose(monitorActive) && !irqStatus && monitorPeriodLength == 24'h000008;
   endsequence

   sequence quiet_period_s;
      !irqStatus [*8] ##1 irqStatus;
   endsequence

   period_reg_a: assert property (periodWrite |=>
      monitorPeriodLength == $past(periodData)) else $error("period lost");
   run_start_a: assert property (monitorEnable |=> monitorActive)
      else $error("monitor did not start");
   run_stop_a: assert property (!monitorEnable |=> !monitorActive)
      else $error("monitor did not stop");
   period_end_a: assert property (entry_s |-> quiet_period_s)
      else $error("period end at wrong cycle");
   hold_idle_a: assert property (!$past(monitorActive) &&
      !$past(holdRead) |-> $stable(holdingValue)) else $error("hold moved");
   read_only_xfer_a: assert property ($past(timerDisable) &&
      $changed(holdingValue) |-> $past(holdRead))
      else $error("transfer without read");
   irq_sticky_a: assert property (irqStatus && !irqClear |=>
      irqStatus) else $error("status dropped");
   irq_clear_a: assert property (irqClear && !monitorActive |=>
      !irqStatus) else $error("status not cleared");
   pin_gate_a: assert property (!$past(irqEnable) |->
      !interrupt_request_pin) else $error("pin high while masked");
   pin_follow_a: assert property ($past(irqStatus) &&
      $past(irqEnable) |-> interrupt_request_pin) else $error("pin low");
endmodule

bind input_power_monitor input_power_monitor_properties i_props (.*);

// file: verification/input_power_monitor_tb_top.sv
/*
 * Self-checking bench for the input power monitor, with a sample source.
 * Assumes a 40 ns mclk and that the design holds no length parameters.
 */
`timescale 1ns/10ps

module input_power_monitor_tb_top;
   import monitor_pkg::*;

   logic              mclk, rst, periodWrite, monitorEnable, timerDisable;
   logic              clearOnRead, irqEnable, irqClear, holdRead;
   logic              monitorActive, irqStatus, interrupt_request_pin;
   logic [MAG_W-1:0]  level, sampleMag;
   logic [SEL_W-1:0]  functionSelect;
   logic [THR_W-1:0]  upperThreshold;
   word_t             periodData, holdingValue, monitorPeriodLength;
   int                fails, total_checks;

   sample_source i_src (.mclk(mclk), .rst(rst), .level(level),
      .sampleMag(sampleMag));

   input_power_monitor i_dut (.mclk(mclk), .rst(rst), .sampleMag(sampleMag),
      .periodWrite(periodWrite), .periodData(periodData),
      .monitorEnable(monitorEnable), .functionSelect(functionSelect),
      .upperThreshold(upperThreshold), .timerDisable(timerDisable),
      .clearOnRead(clearOnRead), .irqEnable(irqEnable), .irqClear(irqClear),
      .holdRead(holdRead), .holdingValue(holdingValue),
      .monitorPeriodLength(monitorPeriodLength),
      .monitorActive(monitorActive), .irqStatus(irqStatus),
      .interrupt_request_pin(interrupt_request_pin));

   // ==========================================================
   // Tasks.
   task automatic test_done();
      $display("Checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input word_t exp, input word_t got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Optionally clears the status, then waits for the next period end.
   task automatic waitIrq(input logic clr);
      int n;
      n = 0;
      if (clr) begin
         @(posedge mclk) irqClear <= 1'b1;
         @(posedge mclk) irqClear <= 1'b0;
      end
      #1;
      while (irqStatus !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      check("period end", 24'h000001, {23'h0, irqStatus});
   endtask

   // Idles the monitor, clears the status, sets the mode and re-enters it.
   task automatic runMode(input logic [1:0] sel, input logic [9:0] thr,
                          input logic [14:0] lvl, input word_t exp);
      @(posedge mclk) monitorEnable <= 1'b0;
      @(posedge mclk) irqClear <= 1'b1;
      functionSelect <= sel;
      upperThreshold <= thr;
      level <= lvl;
      @(posedge mclk) irqClear <= 1'b0;
      tick(2);
      @(posedge mclk) monitorEnable <= 1'b1;
      waitIrq(1'b0);
      check("holding", exp, holdingValue);
      check("pin", {23'h0, irqEnable},
            {23'h0, interrupt_request_pin});
   endtask

   task automatic readHold(input word_t exp);
      @(posedge mclk) holdRead <= 1'b1;
      @(posedge mclk) holdRead <= 1'b0;
      #1;
      check("read holding", exp, holdingValue);
   endtask

   function automatic word_t meanFmt(input word_t s);
      int    e;
      word_t sh;
      e = 0;
      while (e < 15 && s[23-e] === 1'b0) begin
         e++;
      end
      sh = s << e;
      return {e[3:0], sh[23:4]};
   endfunction

   // ==========================================================
   // Clock, watchdog and test sequence.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   initial begin
      repeat (3000) @(posedge mclk);
      fails++;
      $display("MISMATCH watchdog expected end seen timeout");
      test_done();
   end

   initial begin
      {rst, irqEnable, clearOnRead} = 3'h7;
      {periodWrite, monitorEnable, timerDisable, irqClear, holdRead} = 5'h00;
      {level, functionSelect, upperThreshold, periodData} = '0;
      {fails, total_checks} = '0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      #1;
      check("reset", 24'h000000,
            holdingValue | monitorPeriodLength |
            {21'h0, monitorActive, irqStatus, interrupt_request_pin});
      @(posedge mclk) periodWrite <= 1'b1;
      periodData <= 24'h000008;
      @(posedge mclk) periodWrite <= 1'b0;
      #1;
      check("period", 24'h000008, monitorPeriodLength);
      runMode(2'h0, 10'h000, 15'h1234, 24'h001234);
      @(posedge mclk) level <= 15'h7FFF;
      @(posedge mclk) level <= 15'h0100;
      readHold(24'h001234);
      waitIrq(1'b1);
      check("peak", 24'h007FFF, holdingValue);
      waitIrq(1'b1);
      check("peak restart", 24'h000100, holdingValue);
      $display("Test peak finished");
      @(posedge mclk) irqEnable <= 1'b0;
      runMode(2'h1, 10'h000, 15'h1200, meanFmt(24'd72));
      waitIrq(1'b1);
      check("mean restart", meanFmt(24'd72), holdingValue);
      $display("Test mean finished");
      @(posedge mclk) irqEnable <= 1'b1;
      for (int s = 2; s < 4; s++) begin
         runMode(s[1:0], 10'h08F, 15'h1200, 24'h000007);
         waitIrq(1'b1);
         check("count restart", 24'h000007, holdingValue);
      end
      runMode(2'h3, 10'h090, 15'h1200, 24'h000000);
      $display("Test threshold finished");
      @(posedge mclk) timerDisable <= 1'b1;
      clearOnRead <= 1'b0;
      runMode(2'h0, 10'h000, 15'h2222, 24'h000000);
      readHold(24'h002222);
      @(posedge mclk) level <= 15'h0050;
      tick(4);
      readHold(24'h002222);
      @(posedge mclk) clearOnRead <= 1'b1;
      readHold(24'h002222);
      tick(4);
      readHold(24'h000050);
      $display("Test read transfer finished");
      test_done();
   end
endmodule
